//--- core/pmc_control_pins.sv
// MAC-side transmit control, line status, soft reset and clock output pins.
`timescale 1ns/1ps
module pmc_control_pins import pmc_pkg::*; #(
	parameter int DEPTH = STICKY_DEPTH,
	parameter int WIDTH = STICKY_WIDTH
) (
	input  wire logic                     ref_clk,
	input  wire logic                     reset_n,
	input  wire logic                     gtx_clk,
	input  wire logic                     rgmii_mode,
	input  wire logic                     soft_reset_n,
	input  wire logic                     oscillator_select,
	input  wire logic [CFG_WIDTH-1:0]     config_strap_pins,
	input  wire logic                     tx_en,
	input  wire logic                     tx_er_ctl,
	input  wire logic                     carrier_detect,
	input  wire logic                     collision_detect,
	input  wire logic                     full_duplex,
	input  wire logic                     sticky_wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] sticky_addr,
	input  wire logic [WIDTH-1:0]         sticky_wr_data,
	output logic      [WIDTH-1:0]         sticky_rd_data,
	output logic                          crs,
	output logic                          col,
	output logic                          tx_enable_seen,
	output logic                          tx_error_seen,
	output logic                          power_down,
	output logic                          osc_enabled,
	output logic                          reference_clock_output,
	output logic                          reference_clock_output_oe_n
);
	localparam int CNT_W = (REFERENCE_CLOCK_OUTPUT_HALF_CYC > 1) ? $clog2(REFERENCE_CLOCK_OUTPUT_HALF_CYC) : 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REFERENCE_CLOCK_OUTPUT_HALF_CYC - 1);

	// Refuse shapes the logic cannot serve.
	initial begin
		if (DEPTH < 2) $error("Sticky bank needs at least two entries.");
		if (WIDTH < 1 || WIDTH > STICKY_WIDTH) $error("Sticky width out of range.");
		if (REFERENCE_CLOCK_OUTPUT_HALF_CYC < 1) $error("Clock output faster than the reference.");
		if (CFG_REFERENCE_CLOCK_OUTPUT_BIT >= CFG_WIDTH) $error("Clock output strap bit out of range.");
	end

	pmc_tx_if tx_bus ();

	logic [CFG_WIDTH+2:0] pins_s;
	logic                 rgmii_s;
	logic                 soft_n_s;
	logic                 osc_s;
	logic [CFG_WIDTH-1:0] cfg_s;
	logic [1:0]           tx_s;

	// Link sampler runs on the MAC transmit clock.
	pmc_tx_sampler u_sampler (
		.gtx_clk   (gtx_clk),
		.reset_n   (reset_n),
		.rgmii_mode(rgmii_mode),
		.tx_en     (tx_en),
		.tx_er_ctl (tx_er_ctl),
		.tx_o      (tx_bus.sampler)
	);

	// Pin straps and soft reset come from outside the clock domain.
	pmc_sync #(.WIDTH(CFG_WIDTH + 3)) u_pin_sync (
		.clk      (ref_clk),
		.async_in ({rgmii_mode, soft_reset_n, oscillator_select, config_strap_pins}),
		.sync_out (pins_s)
	);

	// Transmit status levels cross from the link domain.
	pmc_sync #(.WIDTH(2)) u_tx_sync (
		.clk      (ref_clk),
		.async_in ({tx_bus.tx_valid, tx_bus.tx_error}),
		.sync_out (tx_s)
	);

	assign rgmii_s  = pins_s[CFG_WIDTH+2];
	assign soft_n_s = pins_s[CFG_WIDTH+1];
	assign osc_s    = pins_s[CFG_WIDTH];
	assign cfg_s    = pins_s[CFG_WIDTH-1:0];

	logic rgmii_q;
	logic rgmii_d;
	logic pd_q;
	logic pd_d;
	logic crs_q;
	logic crs_d;
	logic col_q;
	logic col_d;
	logic txv_q;
	logic txv_d;
	logic txe_q;
	logic txe_d;

	// Line status and power state follow mode, duplex and soft reset.
	always_comb begin
		rgmii_d = rgmii_s;
		pd_d    = ~soft_n_s;
		crs_d   = 1'b0;
		col_d   = 1'b0;
		txv_d   = tx_s[1] & ~pd_q;
		txe_d   = tx_s[0] & ~pd_q;
		if (!rgmii_q && !pd_q) begin
			crs_d = carrier_detect;
			col_d = collision_detect & ~full_duplex;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rgmii_q <= 1'b0;
			pd_q    <= 1'b1;
			crs_q   <= 1'b0;
			col_q   <= 1'b0;
			txv_q   <= 1'b0;
			txe_q   <= 1'b0;
		end else begin
			rgmii_q <= rgmii_d;
			pd_q    <= pd_d;
			crs_q   <= crs_d;
			col_q   <= col_d;
			txv_q   <= txv_d;
			txe_q   <= txe_d;
		end
	end

	assign crs            = crs_q;
	assign col            = col_q;
	assign tx_enable_seen = txv_q;
	assign tx_error_seen  = txe_q;
	assign power_down     = pd_q;

	pmc_ck_state_t    ck_q;
	pmc_ck_state_t    ck_d;
	logic             osc_q;
	logic             osc_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             clk_q;
	logic             clk_d;
	logic             oe_n_q;
	logic             oe_n_d;

	// Shared oscillator select and clock output pin controller.
	always_comb begin
		ck_d   = ck_q;
		osc_d  = osc_q;
		cnt_d  = cnt_q;
		clk_d  = clk_q;
		oe_n_d = oe_n_q;
		case (ck_q)
			PMC_CK_HOLD: begin
				osc_d  = osc_s;
				ck_d   = PMC_CK_RUN;
				oe_n_d = 1'b0;
				clk_d  = 1'b0;
				cnt_d  = '0;
			end
			PMC_CK_RUN: begin
				oe_n_d = 1'b0;
				if (cfg_s[CFG_REFERENCE_CLOCK_OUTPUT_BIT]) begin
					if (cnt_q == CNT_LAST) begin
						cnt_d = '0;
						clk_d = ~clk_q;
					end else begin
						cnt_d = cnt_q + 1'b1;
					end
				end else begin
					clk_d = 1'b0;
					cnt_d = '0;
				end
			end
			default: begin
				ck_d = PMC_CK_HOLD;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ck_q   <= PMC_CK_HOLD;
			osc_q  <= OSC_EN_RESET;
			cnt_q  <= '0;
			clk_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			ck_q   <= ck_d;
			osc_q  <= osc_d;
			cnt_q  <= cnt_d;
			clk_q  <= clk_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign osc_enabled                 = osc_q;
	assign reference_clock_output      = clk_q;
	assign reference_clock_output_oe_n = oe_n_q;

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [WIDTH-1:0] rd_q;
	logic [WIDTH-1:0] rd_d;

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (sticky_wr_en && !pd_q) begin
			mem_d[sticky_addr] = sticky_wr_data;
		end
		rd_d = mem_q[sticky_addr];
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= STICKY_RESET[WIDTH-1:0];
			end
			rd_q <= STICKY_RESET[WIDTH-1:0];
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= mem_d[i];
			end
			rd_q <= rd_d;
		end
	end

	assign sticky_rd_data = rd_q;

	duplex_col_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		$past(full_duplex) |-> !col_q)
		else $error("Collision asserted in full duplex.");

	half_col_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!rgmii_q && !pd_q && !full_duplex && collision_detect) |=> col_q)
		else $error("Collision not reported in half duplex.");

	carrier_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!rgmii_q && !pd_q) |=> (crs_q == $past(carrier_detect)))
		else $error("Carrier sense does not follow carrier.");

	rgmii_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		rgmii_q |=> (!crs_q && !col_q))
		else $error("Status driven in RGMII mode.");

	soft_power_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(!soft_reset_n ##1 !soft_reset_n ##1 !soft_reset_n) |=> pd_q)
		else $error("Soft reset did not power down.");

	sticky_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(pd_q && sticky_wr_en)
		|=> (mem_q[$past(sticky_addr)] == $past(mem_q[sticky_addr])))
		else $error("Sticky register changed while powered down.");

	osc_latch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(reset_n && ck_q == PMC_CK_HOLD) |=> (osc_q == $past(osc_s)) ##1 $stable(osc_q))
		else $error("Oscillator select not latched at release.");

	reset_idle_a: assert property (@(posedge ref_clk)
		$rose(reset_n) |-> (oe_n_q && !clk_q))
		else $error("Clock output active during hard reset.");

	disabled_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ck_q == PMC_CK_RUN && !cfg_s[CFG_REFERENCE_CLOCK_OUTPUT_BIT]) |=> (!clk_q && !oe_n_q))
		else $error("Disabled clock output not held low.");

	clk_toggle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ck_q == PMC_CK_RUN && cfg_s[CFG_REFERENCE_CLOCK_OUTPUT_BIT] && cnt_q == CNT_LAST)
		|=> (clk_q != $past(clk_q)))
		else $error("Clock output did not toggle.");

	hard_clear_a: assert property (@(posedge ref_clk)
		$rose(reset_n) |-> (rd_q == STICKY_RESET[WIDTH-1:0] && pd_q && !crs_q))
		else $error("Hard reset left state off default.");

	pd_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		pd_q |=> (!txv_q && !txe_q && !crs_q && !col_q))
		else $error("Status driven while powered down.");

	osc_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
		(ck_q == PMC_CK_RUN) |=> $stable(osc_q))
		else $error("Oscillator select changed after the latch.");
endmodule // pmc_control_pins

//--- core/pmc_sync.sv
// Two-flop synchroniser for a group of independent levels.
`timescale 1ns/1ps
module pmc_sync import pmc_pkg::*; #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	initial begin
		if (WIDTH < 1) $error("pmc_sync needs WIDTH of at least one.");
	end

	// The first stage feeds only the second stage.
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// Both stages register every rising edge.
	always_ff @(posedge clk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	assign sync_out = sync_q;
endmodule // pmc_sync

//--- core/pmc_tx_sampler.sv
// Link-domain sampler of the GMII and RGMII transmit control pins.
`timescale 1ns/1ps
module pmc_tx_sampler import pmc_pkg::*; (
	input  wire logic   gtx_clk,
	input  wire logic   reset_n,
	input  wire logic   rgmii_mode,
	input  wire logic   tx_en,
	input  wire logic   tx_er_ctl,
	pmc_tx_if.sampler   tx_o
);
	logic [1:0] link_s;
	logic       rst_link_n;
	logic       rgmii_l;
	logic       rise_q;
	logic       rise_d;
	logic       fall_q;
	logic       valid_q;
	logic       valid_d;
	logic       error_q;
	logic       error_d;

	// Reset and mode straps enter the link domain through two flops.
	pmc_sync #(.WIDTH(2)) u_link_sync (
		.clk      (gtx_clk),
		.async_in ({reset_n, rgmii_mode}),
		.sync_out (link_s)
	);
	assign rst_link_n = link_s[1];
	assign rgmii_l    = link_s[0];

	always_ff @(negedge gtx_clk) begin
		fall_q <= tx_er_ctl;
	end

	// Rising half then falling half pair into one enable and error decision.
	always_comb begin
		rise_d  = tx_er_ctl;
		valid_d = 1'b0;
		error_d = 1'b0;
		if (rgmii_l) begin
			valid_d = rise_q;
			error_d = rise_q ^ fall_q;
		end else begin
			valid_d = tx_en;
			error_d = tx_er_ctl;
		end
	end

	// Link-side registers.
	always_ff @(posedge gtx_clk) begin
		if (!rst_link_n) begin
			rise_q  <= 1'b0;
			valid_q <= 1'b0;
			error_q <= 1'b0;
		end else begin
			rise_q  <= rise_d;
			valid_q <= valid_d;
			error_q <= error_d;
		end
	end

	assign tx_o.tx_valid = valid_q;
	assign tx_o.tx_error = error_q;

	gmii_enable_a: assert property (@(posedge gtx_clk) disable iff (!rst_link_n)
		(rst_link_n && !rgmii_l && $stable(rgmii_l)) |=> (valid_q == $past(tx_en)))
		else $error("GMII transmit enable not sampled.");

	gmii_error_a: assert property (@(posedge gtx_clk) disable iff (!rst_link_n)
		(rst_link_n && !rgmii_l && $stable(rgmii_l)) |=> (error_q == $past(tx_er_ctl)))
		else $error("GMII transmit error not sampled.");

	rgmii_error_a: assert property (@(posedge gtx_clk) disable iff (!rst_link_n)
		(rst_link_n && rgmii_l && $stable(rgmii_l))
		|=> (error_q == ($past(rise_q) ^ $past(fall_q))))
		else $error("RGMII transmit error not recovered by XOR.");

	rgmii_valid_a: assert property (@(posedge gtx_clk) disable iff (!rst_link_n)
		(rst_link_n && rgmii_l && $stable(rgmii_l)) |=> (valid_q == $past(rise_q)))
		else $error("RGMII transmit enable not taken from the rising half.");
endmodule // pmc_tx_sampler

//--- pkg/pmc_pkg.sv
// Shared constants for the MAC-side control pin block.
// Function
// - GMII: transmit error sampled each gtx clock rising edge as data error flag.
// - RGMII: rising-edge sample of transmit control is transmit enable.
// - RGMII: falling-edge sample of transmit control carries enable combined with error.
// - GMII: transmit enable sampled on gtx clock rising edge marks valid data.
// - RGMII: separate enable input ignored; carrier sense and collision unused.
// - GMII: carrier sense asserted while a valid carrier is detected.
// - GMII half duplex: collision asserted whenever a collision is detected.
// - Full duplex: collision output held low at all times.
// - Soft reset held low puts the device in a low-power state.
// - Soft reset keeps sticky registers; hard reset returns them to defaults.
// - Oscillator select latched at hard reset release; high enables on-chip oscillator.
// - After release and latch the shared pin is a strap-enabled clock output.
// - Clock output inactive during hard reset and driven low when disabled.
// - Hard reset powers down and returns every register bit to its default.
package pmc_pkg;

	// Clock rates in MHz.
	localparam int REF_CLK_MHZ     = 250;
	localparam int REFERENCE_CLOCK_OUTPUT_MHZ      = 125;
	localparam int EXT_REF_LOW_MHZ = 25;
	localparam int EXT_REF_HI_MHZ  = 125;

	// Reference cycles per half period of the clock output.
	localparam int REFERENCE_CLOCK_OUTPUT_HALF_CYC = REF_CLK_MHZ / (2 * REFERENCE_CLOCK_OUTPUT_MHZ);

	// Synchroniser depth.
	localparam int SYNC_STAGES = 2;

	// Configuration strap layout.
	localparam int CFG_WIDTH      = 5;
	localparam int CFG_REFERENCE_CLOCK_OUTPUT_BIT = 4;

	// Sticky register bank shape and reset content.
	localparam int          STICKY_DEPTH = 8;
	localparam int          STICKY_WIDTH = 16;
	localparam logic [15:0] STICKY_RESET = 16'h0000;

	// Oscillator select default before the strap is caught.
	localparam logic OSC_EN_RESET = 1'b1;

	// Clock output pin controller states.
	typedef enum logic [0:0] {
		PMC_CK_HOLD,
		PMC_CK_RUN
	} pmc_ck_state_t;

endpackage

//--- pkg/pmc_tx_if.sv
// Transmit control status carried from the link sampler to the core.
`timescale 1ns/1ps
interface pmc_tx_if;
	logic tx_valid;
	logic tx_error;

	// The sampler drives in the link domain; the core only synchronises.
	modport sampler (output tx_valid, output tx_error);
	modport core    (input  tx_valid, input  tx_error);
endinterface

//--- test/phy_mac_side_control_pins_bench.sv
// Self-checking bench of the MAC-side control pin block.
`timescale 1ns/1ps
module phy_mac_side_control_pins_bench import pmc_pkg::*;;
	logic                    ref_clk, reset_n, run_clk, rgmii_mode, soft_reset_n;
	logic                    oscillator_select, carrier_detect, collision_detect;
	logic                    full_duplex, sticky_wr_en, frame_en, frame_er;
	logic                    gtx_clk, tx_en, tx_er_ctl, crs, col, power_down, osc_enabled;
	logic                    tx_enable_seen, tx_error_seen, ck_out, ck_oe_n, ck_prev;
	logic [CFG_WIDTH-1:0]    config_strap_pins;
	logic [2:0]              sticky_addr;
	logic [STICKY_WIDTH-1:0] sticky_wr_data, sticky_rd_data;
	int                      error_cnt, n_tests, cyc_cnt;

	pmc_control_pins pmc_control_pins_i (
		.ref_clk(ref_clk), .reset_n(reset_n), .gtx_clk(gtx_clk), .rgmii_mode(rgmii_mode),
		.soft_reset_n(soft_reset_n), .oscillator_select(oscillator_select),
		.config_strap_pins(config_strap_pins), .tx_en(tx_en), .tx_er_ctl(tx_er_ctl),
		.carrier_detect(carrier_detect), .collision_detect(collision_detect),
		.full_duplex(full_duplex), .sticky_wr_en(sticky_wr_en), .sticky_addr(sticky_addr),
		.sticky_wr_data(sticky_wr_data), .sticky_rd_data(sticky_rd_data), .crs(crs),
		.col(col), .tx_enable_seen(tx_enable_seen), .tx_error_seen(tx_error_seen),
		.power_down(power_down), .osc_enabled(osc_enabled),
		.reference_clock_output(ck_out), .reference_clock_output_oe_n(ck_oe_n)
	);

	pmc_mac_model pmc_mac_model_i (
		.run_clk(run_clk), .rgmii_mode(rgmii_mode), .frame_en(frame_en),
		.frame_er(frame_er), .gtx_clk(gtx_clk), .tx_en(tx_en), .tx_er_ctl(tx_er_ctl)
	);

	// Core clock of 4 ns.
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// Cycle ceiling that cuts a hang short.
	always @(posedge ref_clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 4000) begin
			error_cnt++;
			end_of_test();
		end
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			error_cnt++;
		end
	endtask

	task automatic end_of_test();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Hard reset for ten cycles with the link clock running, checking held outputs.
	task automatic hard_rst(input logic osc);
		reset_n           <= 1'b0;
		run_clk           <= 1'b1;
		oscillator_select <= osc;
		cyc(10);
		chk(power_down, 1'b1);
		chk(ck_oe_n, 1'b1);
		chk(ck_out, 1'b0);
		reset_n <= 1'b1;
		cyc(4);
		chk(osc_enabled, osc);
	endtask

	// Clock output runs when the strap enables it and is held low otherwise.
	task automatic t_reference_clock_output();
		config_strap_pins <= 5'h10;
		cyc(4);
		ck_prev = ck_out;
		cyc(1);
		chk(ck_out, !ck_prev);
		chk(ck_oe_n, 1'b0);
		config_strap_pins <= 5'h00;
		cyc(4);
		chk(ck_out, 1'b0);
		chk(ck_oe_n, 1'b0);
	endtask

	// Carrier and collision in GMII, half and full duplex, and silence in RGMII.
	task automatic t_media();
		carrier_detect   <= 1'b1;
		collision_detect <= 1'b1;
		cyc(3);
		chk(crs, 1'b1);
		chk(col, 1'b1);
		full_duplex <= 1'b1;
		cyc(3);
		chk(col, 1'b0);
		chk(crs, 1'b1);
		full_duplex <= 1'b0;
		rgmii_mode  <= 1'b1;
		cyc(6);
		chk({crs, col}, 2'h0);
		rgmii_mode       <= 1'b0;
		carrier_detect   <= 1'b0;
		collision_detect <= 1'b0;
		cyc(6);
		chk({crs, col}, 2'h0);
	endtask

	// One frame state held for a while, then enable and error as seen by the core.
	task automatic frame(input logic rg, input logic en, input logic er, input logic [1:0] exp);
		rgmii_mode <= rg;
		frame_en   <= en;
		frame_er   <= er;
		cyc(30);
		chk({tx_enable_seen, tx_error_seen}, exp);
	endtask

	// Transmit enable and error in both modes, including an ignored GMII enable.
	task automatic t_tx();
		frame(1'b0, 1'b1, 1'b0, 2'h2);
		frame(1'b0, 1'b1, 1'b1, 2'h3);
		frame(1'b0, 1'b0, 1'b1, 2'h1);
		frame(1'b1, 1'b1, 1'b0, 2'h2);
		frame(1'b1, 1'b1, 1'b1, 2'h3);
		frame(1'b1, 1'b0, 1'b1, 2'h1);
		frame(1'b1, 1'b0, 1'b0, 2'h0);
		rgmii_mode <= 1'b0;
		cyc(10);
	endtask

	// Sticky content survives soft reset, refuses writes then, and clears on hard reset.
	task automatic t_soft();
		sticky_addr    <= 3'h3;
		sticky_wr_data <= 16'hA5C3;
		sticky_wr_en   <= 1'b1;
		cyc(1);
		sticky_wr_en   <= 1'b0;
		carrier_detect <= 1'b1;
		soft_reset_n   <= 1'b0;
		frame_en       <= 1'b1;
		cyc(6);
		chk(power_down, 1'b1);
		chk(crs, 1'b0);
		chk(tx_enable_seen, 1'b0);
		sticky_wr_data <= 16'h1234;
		sticky_wr_en   <= 1'b1;
		cyc(1);
		sticky_wr_en <= 1'b0;
		soft_reset_n <= 1'b1;
		cyc(6);
		chk(power_down, 1'b0);
		chk(sticky_rd_data, 16'hA5C3);
		chk(tx_enable_seen, 1'b1);
		carrier_detect <= 1'b0;
		frame_en       <= 1'b0;
		hard_rst(1'b1);
		cyc(2);
		chk(sticky_rd_data, 16'h0000);
	endtask

	// Main sequence.
	initial begin
		error_cnt = 0;
		n_tests   = 0;
		cyc_cnt   = 0;
		{reset_n, run_clk, rgmii_mode, oscillator_select, carrier_detect} = 5'h00;
		{collision_detect, full_duplex, sticky_wr_en, frame_en, frame_er} = 5'h00;
		soft_reset_n      = 1'b1;
		config_strap_pins = 5'h00;
		sticky_addr       = 3'h0;
		sticky_wr_data    = 16'h0000;
		@(posedge ref_clk);
		hard_rst(1'b0);
		t_reference_clock_output();
		t_media();
		t_tx();
		t_soft();
		end_of_test();
	end
endmodule // phy_mac_side_control_pins_bench

//--- test/pmc_mac_model.sv
// Behavioural MAC driving the transmit clock and transmit control pins.
`timescale 1ns/1ps
module pmc_mac_model (
	input  wire logic run_clk,
	input  wire logic rgmii_mode,
	input  wire logic frame_en,
	input  wire logic frame_er,
	output logic      gtx_clk,
	output logic      tx_en,
	output logic      tx_er_ctl
);
	// Link clock of 15 ns that stands low when stopped, offset from the core clock.
	initial begin
		gtx_clk   = 1'b0;
		tx_en     = 1'b0;
		tx_er_ctl = 1'b0;
		#1.3;
		forever begin
			#7.5;
			gtx_clk = run_clk ? ~gtx_clk : 1'b0;
		end
	end

	// GMII enable and error change just after a rising edge.
	// In RGMII the unused enable pin shows the opposite level, to be ignored.
	// RGMII falling half carries enable XOR error.
	// RGMII rising half carries enable, set up after the falling edge.
	always @(gtx_clk) begin
		#1;
		if (gtx_clk) begin
			tx_en     <= rgmii_mode ? ~frame_en : frame_en;
			tx_er_ctl <= rgmii_mode ? (frame_en ^ frame_er) : frame_er;
		end else if (rgmii_mode) begin
			tx_er_ctl <= frame_en;
		end
	end
endmodule // pmc_mac_model
